// >>> spv_port.v
// serial program/verify port of a small 12-bit core: command decoder,
// load and read frames, program counter, code protection gating.
// assumes an external array on mem_* that reads mem_rdata from mem_addr
// and burns mem_wdata while mem_prog is high; pins are asynchronous.
`timescale 1ns/1ps
`include "spv_defs.vh"

module spv_port #(
    parameter LARGE_MEM = 0,
    parameter HAS_CALIB = 1
) (
    input wire clock,
    input wire rstn,
    input wire serial_clock_pin,
    input wire serial_data_pin_in,
    output reg serial_data_pin_out,
    output reg serial_data_pin_oe_n,
    input wire master_clear_vpp_pin,
    input wire code_protect_bit,
    input wire [11:0] mem_rdata,
    output reg [11:0] mem_addr,
    output reg [11:0] mem_wdata,
    output reg mem_prog,
    output reg prog_mode,
    output reg load_overrun
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [3:0] S_OFF = 4'b0001;
    localparam [3:0] S_CMD = 4'b0010;
    localparam [3:0] S_LOAD = 4'b0100;
    localparam [3:0] S_READ = 4'b1000;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // highest protected address for this variant
    function [11:0] prot_top;
        input dummy;
        reg [11:0] top;
        begin
            top = (LARGE_MEM != 0) ? `SPV_LAST_LARGE : `SPV_LAST_SMALL;
            if (HAS_CALIB != 0) begin
                top = top - `SPV_PC_ONE;
            end
            prot_top = top;
        end
    endfunction

    // protection is on when the protect bit is programmed (reads zero)
    function is_protected;
        input [11:0] addr;
        input cp;
        begin
            is_protected = !cp && (addr > `SPV_OPEN_TOP)
                && (addr <= prot_top(1'b0));
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    reg [1:0] sclk_s;
    reg [1:0] sdat_s;
    reg [1:0] vpp_s;
    reg sclk_d;
    reg vpp_d;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_s <= 2'b00;
            sdat_s <= 2'b00;
            vpp_s <= 2'b00;
            sclk_d <= 1'b0;
            vpp_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], serial_clock_pin};
            sdat_s <= {sdat_s[0], serial_data_pin_in};
            vpp_s <= {vpp_s[0], master_clear_vpp_pin};
            sclk_d <= sclk_s[1];
            vpp_d <= vpp_s[1];
        end
    end

    wire sclk_rise = sclk_s[1] & ~sclk_d;
    wire sclk_fall = ~sclk_s[1] & sclk_d;
    wire vpp_rise = vpp_s[1] & ~vpp_d;
    wire din = sdat_s[1];

    // ------------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------------
    reg [3:0] state;
    reg [4:0] cnt;
    reg [5:0] cmd;
    reg [13:0] shreg;
    reg push_valid;
    reg [11:0] push_data;

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [11:0] fifo_out_data;

    // lsb arrives first, so each new bit enters at the top
    wire [5:0] next_cmd = {din, cmd[5:1]};
    wire cmd_done = (state == S_CMD) && sclk_fall
        && (cnt == `SPV_CMD_LAST);
    wire do_begin = cmd_done && (next_cmd == `SPV_CMD_BEGIN);
    wire addr_prot = is_protected(mem_addr, code_protect_bit);

    // protected words read as zero; upper two bits always zero
    wire [11:0] read_core = addr_prot ? 12'h000 : mem_rdata;
    wire [13:0] read_word = {2'b00, read_core};

    // ------------------------------------------------------------------
    // load buffer: a word waits here until begin programming takes it
    // ------------------------------------------------------------------
    spv_fifo #(
        .WIDTH(`SPV_CORE_BITS),
        .DEPTH(`SPV_FIFO_DEPTH),
        .AW(`SPV_FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(do_begin),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= S_OFF;
            cnt <= 5'h00;
            cmd <= 6'h00;
            shreg <= 14'h0000;
            push_valid <= 1'b0;
            push_data <= 12'h000;
            mem_addr <= `SPV_PC_RESET;
            mem_wdata <= 12'h000;
            mem_prog <= 1'b0;
            prog_mode <= 1'b0;
            load_overrun <= 1'b0;
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe_n <= 1'b1;
        end else begin
            push_valid <= 1'b0;
            load_overrun <= 1'b0;
            if (!vpp_s[1]) begin
                // master clear low: counter parked at all ones, pin released
                state <= S_OFF;
                cnt <= 5'h00;
                mem_addr <= `SPV_PC_RESET;
                mem_prog <= 1'b0;
                prog_mode <= 1'b0;
                serial_data_pin_oe_n <= 1'b1;
            end else begin
                case (state)
                    S_OFF: begin
                        // both serial pins must be low as the voltage rises
                        if (vpp_rise && !sclk_s[1] && !din) begin
                            state <= S_CMD;
                            cnt <= 5'h00;
                            prog_mode <= 1'b1;
                        end
                    end
                    S_CMD: begin
                        if (sclk_fall) begin
                            cmd <= next_cmd;
                            cnt <= cnt + 5'h01;
                        end
                        if (cmd_done) begin
                            cnt <= 5'h00;
                            case (next_cmd)
                                `SPV_CMD_LOAD: begin
                                    state <= S_LOAD;
                                end
                                `SPV_CMD_READ: begin
                                    shreg <= read_word;
                                    state <= S_READ;
                                end
                                `SPV_CMD_INC: begin
                                    // 0xfff wraps to 0, last user to id area
                                    mem_addr <= mem_addr
                                        + `SPV_PC_ONE;
                                end
                                `SPV_CMD_BEGIN: begin
                                    // an empty buffer means nothing to burn
                                    if (fifo_out_valid) begin
                                        mem_wdata <= fifo_out_data;
                                        mem_prog <= !addr_prot;
                                    end
                                end
                                `SPV_CMD_END: begin
                                    mem_prog <= 1'b0;
                                end
                                default: begin
                                    state <= S_CMD;
                                end
                            endcase
                        end
                    end
                    S_LOAD: begin
                        if (sclk_fall) begin
                            cnt <= cnt + 5'h01;
                            // start and stop cycles carry nothing
                            if (cnt >= `SPV_DATA_FIRST
                                && cnt <= `SPV_DATA_LAST) begin
                                shreg <= {din, shreg[13:1]};
                            end
                            if (cnt == `SPV_STOP_CYC) begin
                                state <= S_CMD;
                                cnt <= 5'h00;
                                // a full buffer drops the word and flags it
                                push_valid <= fifo_in_ready;
                                load_overrun <= !fifo_in_ready;
                                push_data <= shreg[11:0];
                            end
                        end
                    end
                    S_READ: begin
                        if (sclk_rise) begin
                            cnt <= cnt + 5'h01;
                            if (cnt >= `SPV_DATA_FIRST
                                && cnt <= `SPV_DATA_LAST) begin
                                serial_data_pin_oe_n <= 1'b0;
                                serial_data_pin_out <= shreg[0];
                                shreg <= {1'b0, shreg[13:1]};
                            end
                            if (cnt == `SPV_STOP_CYC) begin
                                serial_data_pin_oe_n <= 1'b1;
                                serial_data_pin_out <= 1'b0;
                            end
                        end
                        if (sclk_fall && cnt == `SPV_FRAME_CYC) begin
                            state <= S_CMD;
                            cnt <= 5'h00;
                        end
                    end
                    default: begin
                        state <= S_OFF;
                    end
                endcase
            end
        end
    end

endmodule // spv_port

// >>> spv_defs.vh
// constants of the serial program/verify port: command codes, frame
// lengths, address map limits and reset values.
// assumes inclusion by bare name from the design files.
`ifndef SPV_DEFS_VH
`define SPV_DEFS_VH

// ----------------------------------------------------------------------
// command codes, six bits, sent lsb first
// ----------------------------------------------------------------------
`define SPV_CMD_LOAD 6'h02
`define SPV_CMD_READ 6'h04
`define SPV_CMD_INC 6'h06
`define SPV_CMD_BEGIN 6'h08
`define SPV_CMD_END 6'h0E

// ----------------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------------
`define SPV_CMD_LAST 5'h05
`define SPV_DATA_FIRST 5'h01
`define SPV_DATA_LAST 5'h0E
`define SPV_STOP_CYC 5'h0F
`define SPV_FRAME_CYC 5'h10
`define SPV_WORD_BITS 14
`define SPV_CORE_BITS 12

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define SPV_PC_RESET 12'hFFF
`define SPV_OPEN_TOP 12'h03F
`define SPV_LAST_SMALL 12'h1FF
`define SPV_LAST_LARGE 12'h3FF
`define SPV_PC_ONE 12'h001

// ----------------------------------------------------------------------
// load buffer
// ----------------------------------------------------------------------
`define SPV_FIFO_DEPTH 16
`define SPV_FIFO_AW 4

`endif

// >>> spv_fifo.v
// small first-in first-out buffer with valid/ready on both sides.
// assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module spv_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    localparam [AW:0] FULL = DEPTH;
    localparam [AW:0] ONE = 1;
    localparam [AW-1:0] PTR_ONE = 1;

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != FULL);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = store[rd_ptr];

    always @(posedge clock) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_ONE;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_ONE;
            end
            if (push && !pop) begin
                count <= count + ONE;
            end else if (pop && !push) begin
                count <= count - ONE;
            end
        end
    end

endmodule // spv_fifo

// >>> spv_port_monitor.sv
// checker for the serial program/verify port, watching its ports only.
// assumes one clock domain and the bind below onto spv_port.
`timescale 1ns/1ps

module spv_port_monitor #(
    parameter LARGE_MEM = 0,
    parameter HAS_CALIB = 1
) (
    input wire clock,
    input wire rstn,
    input wire serial_clock_pin,
    input wire serial_data_pin_in,
    input wire serial_data_pin_out,
    input wire serial_data_pin_oe_n,
    input wire master_clear_vpp_pin,
    input wire code_protect_bit,
    input wire [11:0] mem_rdata,
    input wire [11:0] mem_addr,
    input wire [11:0] mem_wdata,
    input wire mem_prog,
    input wire prog_mode,
    input wire load_overrun
);
    // ------
    // helpers: cycles since each raw serial clock edge
    // ------
    reg sck_q;
    reg [3:0] since_rise;
    reg [3:0] since_fall;
    wire [11:0] last = LARGE_MEM ? 12'h3FF : 12'h1FF;
    wire [11:0] top = HAS_CALIB ? last - 12'h001 : last;
    wire locked = !code_protect_bit && mem_addr >= 12'h040 && mem_addr <= top;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            since_rise <= 4'hF;
            since_fall <= 4'hF;
        end else begin
            sck_q <= serial_clock_pin;
            if (serial_clock_pin && !sck_q)
                since_rise <= 4'h0;
            else if (since_rise != 4'hF)
                since_rise <= since_rise + 4'h1;
            if (!serial_clock_pin && sck_q)
                since_fall <= 4'h0;
            else if (since_fall != 4'hF)
                since_fall <= since_fall + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ------
    // assertions
    // ------
    a_oe_in_mode: assert property (
        !serial_data_pin_oe_n |-> prog_mode)
        else $error("data pin driven outside mode");
    a_burn_in_mode: assert property (
        mem_prog |-> prog_mode) else $error("burn outside mode");
    a_pc_held: assert property (
        (!master_clear_vpp_pin) [*5] |->
        mem_addr == 12'hFFF && !prog_mode && !mem_prog)
        else $error("counter not held while vpp low");
    a_addr_step: assert property (
        master_clear_vpp_pin [*6] ##0 $changed(mem_addr) |->
        mem_addr == $past(mem_addr) + 12'h001)
        else $error("address moved by other than one");
    a_addr_timing: assert property (
        $changed(mem_addr) && master_clear_vpp_pin |-> since_fall <= 4'h8)
        else $error("address moved away from a clock fall");
    a_out_timing: assert property (
        !serial_data_pin_oe_n && $changed(serial_data_pin_out) |->
        since_rise <= 4'h8) else $error("read bit moved off a rise");
    a_dir_timing: assert property (
        $changed(serial_data_pin_oe_n) && master_clear_vpp_pin |->
        since_rise <= 4'h8) else $error("pin direction off a rise");
    a_burn_start: assert property (
        $rose(mem_prog) |-> !locked && since_fall <= 4'h8)
        else $error("burn start wrong");
    a_burn_stop: assert property (
        $fell(mem_prog) && master_clear_vpp_pin |-> since_fall <= 4'h8)
        else $error("burn stop off a command");
    a_read_blank: assert property (
        !serial_data_pin_oe_n && locked |-> !serial_data_pin_out)
        else $error("protected word leaked");

    c_read: cover property ($fell(serial_data_pin_oe_n));
    c_burn: cover property ($rose(mem_prog));
    c_overrun: cover property (load_overrun);
endmodule // spv_port_monitor

bind spv_port spv_port_monitor #(.LARGE_MEM(LARGE_MEM),
    .HAS_CALIB(HAS_CALIB)) mon (.clock(clock), .rstn(rstn),
    .serial_clock_pin(serial_clock_pin),
    .serial_data_pin_in(serial_data_pin_in),
    .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe_n(serial_data_pin_oe_n),
    .master_clear_vpp_pin(master_clear_vpp_pin),
    .code_protect_bit(code_protect_bit), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_prog(mem_prog),
    .prog_mode(prog_mode), .load_overrun(load_overrun));

// >>> spv_prog_model.sv
// programmer model: drives serial clock and data, reads frames back.
// assumes the bench resolves the data line from both drivers.
`timescale 1ns/1ps

module spv_prog_model (
    input wire clock,
    input wire data_line,
    input wire dev_oe_n,
    output reg serial_clock_pin,
    output reg drv_en,
    output reg drv_val
);
    // no operating clock is modelled; serial clock idles low between frames
    initial begin
        serial_clock_pin = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b0;
    end

    // ------
    // link timing: four system clocks a half period, 80 ns a cycle
    // ------
    task half;
        begin
            repeat (4) @(posedge clock);
            #1;
        end
    endtask

    task cyc(input b);
        begin
            serial_clock_pin = 1'b1;
            drv_val = b;
            half;
            serial_clock_pin = 1'b0;
            half;
        end
    endtask

    task gap;
        begin
            repeat (100) @(posedge clock);
            #1;
        end
    endtask

    // ------
    // transfers
    // ------
    task send_cmd(input [5:0] code);
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                cyc(code[i]);
            drv_val = 1'b0;
            gap;
        end
    endtask

    task load_frame(input [13:0] w, input fb);
        integer i;
        begin
            cyc(fb);
            for (i = 0; i < 14; i = i + 1)
                cyc(w[i]);
            cyc(fb);
            drv_val = 1'b0;
            gap;
        end
    endtask

    // bits are taken late in the low phase, where the device still holds them
    task read_frame(output [13:0] w, output [15:0] dir);
        integer i;
        begin
            drv_en = 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                cyc(1'b0);
                dir[i] = dev_oe_n;
                if (i > 0 && i < 15)
                    w[i - 1] = data_line;
            end
            drv_en = 1'b1;
            gap;
        end
    endtask
endmodule // spv_prog_model

// >>> spv_port_test.sv
// self-checking bench: programmer model on the pins, array stub on mem_*.
// assumes the port, its buffer and spv_defs.vh compiled alongside.
`timescale 1ns/1ps
`include "spv_defs.vh"

module spv_port_test;
    reg clock;
    reg rstn;
    reg vpp;
    reg cp_bit;
    reg junk;
    wire sck;
    wire drv_en;
    wire drv_val;
    wire data_line;
    wire dev_out;
    wire dev_oe_n;
    wire [11:0] mem_rdata;
    wire [11:0] mem_addr;
    wire [11:0] mem_wdata;
    wire mem_prog;
    wire prog_mode;
    wire load_overrun;
    integer n_mismatch;
    integer checked;
    integer n_over;
    reg [13:0] word;
    reg [15:0] trace;

    // an idle line toggles so a stale level cannot pass for data
    assign data_line = !dev_oe_n ? dev_out : (drv_en ? drv_val : junk);
    assign mem_rdata = mem_addr ^ 12'h5A3;

    spv_port #(.LARGE_MEM(0), .HAS_CALIB(1)) uut (.clock(clock),
        .rstn(rstn), .serial_clock_pin(sck), .serial_data_pin_in(data_line),
        .serial_data_pin_out(dev_out), .serial_data_pin_oe_n(dev_oe_n),
        .master_clear_vpp_pin(vpp), .code_protect_bit(cp_bit),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_prog(mem_prog), .prog_mode(prog_mode),
        .load_overrun(load_overrun));
    spv_prog_model prog (.clock(clock), .data_line(data_line),
        .dev_oe_n(dev_oe_n), .serial_clock_pin(sck), .drv_en(drv_en),
        .drv_val(drv_val));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) junk <= ~junk;
    always @(posedge clock) if (load_overrun === 1'b1) n_over <= n_over + 1;

    // ------
    // shared tasks
    // ------
    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task wait_clk(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask

    task rd(input [13:0] exp);
        begin
            prog.send_cmd(`SPV_CMD_READ);
            prog.read_frame(word, trace);
            check("read word", {2'b00, word}, {2'b00, exp});
            check("pin dir", trace, 16'h8001);
        end
    endtask

    task burn(input [13:0] w, input fb, input on);
        begin
            prog.send_cmd(`SPV_CMD_LOAD);
            prog.load_frame(w, fb);
            prog.send_cmd(`SPV_CMD_BEGIN);
            check("burn on", {15'h0, mem_prog}, {15'h0, on});
        end
    endtask

    // ------
    // scenarios
    // ------
    task t_entry;
        begin
            check("pc reset", {4'h0, mem_addr}, 16'h0FFF);
            check("idle", {13'h0, prog_mode, mem_prog, dev_oe_n},
                16'h0001);
            vpp = 1'b1;
            wait_clk(10);
            check("mode", {15'h0, prog_mode}, 16'h0001);
            rd(14'h0A5C);
            prog.send_cmd(`SPV_CMD_INC);
            check("wrap", {4'h0, mem_addr}, 16'h0000);
            $display("test entry done");
        end
    endtask

    task t_program;
        begin
            burn(14'h3ABC, 1'b1, 1'b1);
            check("burn word", {4'h0, mem_wdata}, 16'h0ABC);
            wait_clk(10000);
            prog.send_cmd(`SPV_CMD_END);
            check("burn off", {15'h0, mem_prog}, 16'h0000);
            rd(14'h05A3);
            $display("test program done");
        end
    endtask

    // the 17th word finds the 16-word buffer full and is dropped
    task t_overrun;
        integer i;
        begin
            n_over = 0;
            for (i = 0; i < 17; i = i + 1) begin
                prog.send_cmd(`SPV_CMD_LOAD);
                prog.load_frame({2'b11, 12'h100 + i[11:0]}, 1'b0);
            end
            check("overrun", n_over[15:0], 16'h0001);
            for (i = 0; i < 16; i = i + 1) begin
                prog.send_cmd(`SPV_CMD_BEGIN);
                check("queued", {4'h0, mem_wdata},
                    16'h0100 + i[15:0]);
                prog.send_cmd(`SPV_CMD_END);
            end
            prog.send_cmd(`SPV_CMD_BEGIN);
            check("empty", {15'h0, mem_prog}, 16'h0000);
            prog.send_cmd(`SPV_CMD_END);
            $display("test overrun done");
        end
    endtask

    task t_protect;
        integer k;
        integer n;
        reg [11:0] a;
        begin
            cp_bit = 1'b0;
            for (k = 0; k < 6; k = k + 1) begin
                case (k)
                    0: a = 12'h000;
                    1: a = 12'h03F;
                    2: a = 12'h040;
                    3: a = 12'h1FE;
                    4: a = 12'h1FF;
                    default: a = 12'h200;
                endcase
                n = 0;
                while (mem_addr !== a && n < 600) begin
                    prog.send_cmd(`SPV_CMD_INC);
                    n = n + 1;
                end
                check("step", {4'h0, mem_addr}, {4'h0, a});
                if (a >= 12'h040 && a <= 12'h1FE)
                    rd(14'h0000);
                else
                    rd({2'b00, a ^ 12'h5A3});
                if (a == 12'h040) begin
                    burn(14'h0123, 1'b0, 1'b0);
                    prog.send_cmd(`SPV_CMD_END);
                end
            end
            vpp = 1'b0;
            wait_clk(10);
            check("exit", {3'h0, prog_mode, mem_addr}, 16'h0FFF);
            vpp = 1'b1;
            wait_clk(10);
            rd(14'h0A5C);
            $display("test protect done");
        end
    endtask

    initial begin
        rstn = 1'b0;
        vpp = 1'b0;
        cp_bit = 1'b1;
        junk = 1'b0;
        n_mismatch = 0;
        checked = 0;
        n_over = 0;
        wait_clk(3);
        rstn = 1'b1;
        wait_clk(2);
        t_entry;
        t_program;
        t_overrun;
        t_protect;
        summarize;
    end

    // the tests need about 1 ms; a tenth more is left for slack
    initial begin
        #1100000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
endmodule // spv_port_test
